// file: pipb_port.sv
package pipb_pkg;
  // Bank shape: nine ports, 46 pins in total
  localparam int PIPB_NPORT = 9;
  localparam int PIPB_NPIN = 46;
  localparam int PIPB_W [PIPB_NPORT] = '{4, 2, 6, 8, 5, 8, 2, 5, 6};
  localparam int PIPB_BASE [PIPB_NPORT] =
    '{0, 4, 6, 12, 20, 25, 33, 35, 40};
  // Which controls each port carries; absent bits read as zero
  localparam logic [7:0] PIPB_FC_MASK [PIPB_NPORT] =
    '{8'h05, 8'h00, 8'h3F, 8'hFF, 8'h1F, 8'hFF, 8'h03, 8'h1F, 8'h3F};
  localparam logic [7:0] PIPB_OC_MASK [PIPB_NPORT] =
    '{8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1F, 8'h3F};
  localparam logic [7:0] PIPB_PU_MASK [PIPB_NPORT] =
    '{8'h00, 8'h03, 8'h3F, 8'hFF, 8'h1F, 8'hFF, 8'h03, 8'h1F, 8'h3F};
  // Bus address layout: port in [8:5], register in [4:2]
  localparam int PIPB_ADR_W = 9;
  localparam int PIPB_PORT_LSB = 5;
  localparam int PIPB_REG_LSB = 2;
  localparam logic [3:0] PIPB_GLOBAL_PORT = 4'h9;
  // Per-port register indices
  localparam logic [2:0] PIPB_R_DATA = 3'h0;
  localparam logic [2:0] PIPB_R_PIN = 3'h1;
  localparam logic [2:0] PIPB_R_DIR = 3'h2;
  localparam logic [2:0] PIPB_R_ALT = 3'h3;
  localparam logic [2:0] PIPB_R_DRV = 3'h4;
  localparam logic [2:0] PIPB_R_PU = 3'h5;
  // Global register indices
  localparam logic [2:0] PIPB_G_ROUTE = 3'h0;
  localparam logic [2:0] PIPB_G_SWAP = 3'h1;
  // Serial route codes for the serial0 field
  localparam logic [1:0] PIPB_S0_SIO_HI = 2'h1;
  localparam logic [1:0] PIPB_S0_SIO_LO = 2'h2;
  // Port 2 pin positions inside the flat pin bus
  localparam int PIPB_P2 = 6;
  localparam int PIPB_P20 = PIPB_P2 + 0;
  localparam int PIPB_P21 = PIPB_P2 + 1;
  localparam int PIPB_P22 = PIPB_P2 + 2;
  localparam int PIPB_P23 = PIPB_P2 + 3;
  localparam int PIPB_P24 = PIPB_P2 + 4;
  localparam int PIPB_P25 = PIPB_P2 + 5;
endpackage

module pipb_port import pipb_pkg::*; #(
  parameter int W = 8,
  parameter logic [7:0] FC_MASK = 8'hFF,
  parameter logic [7:0] OC_MASK = 8'hFF,
  parameter logic [7:0] PU_MASK = 8'hFF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [2:0] reg_idx,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] alt_out,
  input wire logic [W-1:0] alt_oe,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_n,
  output logic [W-1:0] pin_pu
);
  typedef struct packed {
    logic [7:0] dr;
    logic [7:0] cr;
    logic [7:0] fc;
    logic [7:0] oc;
    logic [7:0] pu;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe_n;
    logic [W-1:0] pin_pu;
  } pipb_port_state_type;

  pipb_port_state_type st_reg;
  pipb_port_state_type st_next;
  logic [W-1:0] val;
  logic [W-1:0] drv;
  logic [W-1:0] plain;

  // Register writes and pin driver computation
  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      case (reg_idx)
        PIPB_R_DATA: st_next.dr = wr_data;
        PIPB_R_DIR: st_next.cr = wr_data;
        PIPB_R_ALT: st_next.fc = wr_data & FC_MASK;
        PIPB_R_DRV: st_next.oc = wr_data & OC_MASK;
        PIPB_R_PU: st_next.pu = wr_data & PU_MASK;
        default: ;
      endcase
    end
    // Alternate output replaces the latch where enabled
    val = (st_reg.fc[W-1:0] & alt_out)
      | (~st_reg.fc[W-1:0] & st_reg.dr[W-1:0]);
    // Output mode, peripheral consent, open drain only pulls low
    drv = st_reg.cr[W-1:0] & (~st_reg.fc[W-1:0] | alt_oe)
      & ~(st_reg.oc[W-1:0] & val);
    plain = st_reg.cr[W-1:0] & ~st_reg.fc[W-1:0];
    st_next.pin_out = val & ~st_reg.oc[W-1:0];
    st_next.pin_oe_n = ~drv;
    st_next.pin_pu = st_reg.pu[W-1:0]
      & (~st_reg.cr[W-1:0] | st_reg.oc[W-1:0]);
  end

  // State register; pins released during reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.pin_oe_n <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read mux; pin level is live, never latched
  always_comb begin
    case (reg_idx)
      PIPB_R_DATA: rd_data = st_reg.dr;
      PIPB_R_PIN: rd_data = 8'(pin_in);
      PIPB_R_DIR: rd_data = st_reg.cr;
      PIPB_R_ALT: rd_data = st_reg.fc;
      PIPB_R_DRV: rd_data = st_reg.oc;
      PIPB_R_PU: rd_data = st_reg.pu;
      default: rd_data = 8'h00;
    endcase
  end

  assign pin_out = st_reg.pin_out;
  assign pin_oe_n = st_reg.pin_oe_n;
  assign pin_pu = st_reg.pin_pu;

  pin_live_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_idx == PIPB_R_PIN |-> rd_data == 8'(pin_in))
    else $error("pin read not live");
  input_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 (~$past(st_reg.cr[W-1:0]) & ~pin_oe_n) == '0)
    else $error("input pin driven");
  od_nohigh_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 ($past(st_reg.oc[W-1:0]) & ~pin_oe_n & pin_out) == '0)
    else $error("open drain drove high");
  write_out_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_en && reg_idx == PIPB_R_DATA ##1 plain == '1 && st_reg.oc == '0
    |=> pin_out == $past(st_reg.dr[W-1:0]) && pin_oe_n == '0)
    else $error("written data not on pins next cycle");
  mask_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_reg.fc & ~FC_MASK) == 8'h00 && (st_reg.oc & ~OC_MASK) == 8'h00)
    else $error("absent control bit set");
endmodule

// file: pipb_bank.sv
// Overview of operation
// - Nine bidirectional ports, 46 pins, two to eight pins each.
// - Output-mode pins drive the value held in the port data latch.
// - Pin-level read returns the present level of input pins.
// - Direction register picks input or output mode per pin.
// - Alternate enable lets the peripheral output reach the pin.
// - Driver type picks push-pull or low-only open drain per pin.
// - Pull-up applies to inputs and open-drain outputs when enabled.
// - Output data is latched; input path has no latch; the code registers the peripheral input copies for one cycle.
// - Pins are sampled in the read cycle; debounce is software's job.
// - Written data reaches the pin in the cycle after the write.
// - Each port carries only the controls its pins need.
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
module pipb_bank import pipb_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [PIPB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [PIPB_NPIN-1:0] pin_in,
  output logic [PIPB_NPIN-1:0] pin_out,
  output logic [PIPB_NPIN-1:0] pin_oe_n,
  output logic [PIPB_NPIN-1:0] pin_pullup,
  input wire logic [PIPB_NPIN-1:0] alt_out_i,
  input wire logic [PIPB_NPIN-1:0] alt_oe_i,
  input wire logic uart0_txd,
  input wire logic sio0_sclk_out,
  input wire logic sio0_so,
  input wire logic twi_scl_low,
  input wire logic twi_sda_low,
  output logic uart0_rxd,
  output logic sio0_si,
  output logic sio0_sclk_in,
  output logic twi_scl_in,
  output logic twi_sda_in
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [2:0] route;
    logic swap;
    logic rxd;
    logic si;
    logic sclk;
    logic scl;
    logic sda;
  } pipb_top_state_type;

  pipb_top_state_type st_reg;
  pipb_top_state_type st_next;
  logic [3:0] port_sel;
  logic [2:0] reg_idx;
  logic req;
  logic wr_now;
  logic [1:0] s0;
  logic s2;
  logic uart_on;
  logic sio_lo;
  logic [PIPB_NPIN-1:0] alt_all;
  logic [PIPB_NPIN-1:0] oe_all;
  logic [7:0] port_rd [PIPB_NPORT];
  logic [PIPB_NPORT-1:0] port_wr;

  // Address decode; writes land on the edge that samples ack
  assign port_sel = wb_adr_i[PIPB_ADR_W-1:PIPB_PORT_LSB];
  assign reg_idx = wb_adr_i[PIPB_PORT_LSB-1:PIPB_REG_LSB];
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_now = req & wb_we_i & st_reg.ack & wb_sel_i[0];

  // Route field decode for port 2
  assign s0 = st_reg.route[1:0];
  assign s2 = st_reg.route[2];
  assign uart_on = !s0[1] && !s2;
  assign sio_lo = s0 == PIPB_S0_SIO_LO && !s2;

  // Alternate outputs; port 2 taken from the serial routing
  always_comb begin
    alt_all = alt_out_i;
    oe_all = alt_oe_i;
    alt_all[PIPB_P25:PIPB_P20] = 6'h00;
    oe_all[PIPB_P25:PIPB_P20] = 6'h00;
    if (!s0[0]) begin
      // Two-wire bus pulls low only
      oe_all[PIPB_P24] = twi_scl_low;
      oe_all[PIPB_P23] = twi_sda_low;
    end
    if (s0 == PIPB_S0_SIO_HI) begin
      alt_all[PIPB_P25] = sio0_sclk_out;
      oe_all[PIPB_P25] = 1'b1;
      alt_all[PIPB_P23] = sio0_so;
      oe_all[PIPB_P23] = 1'b1;
    end
    if (sio_lo) begin
      alt_all[PIPB_P22] = sio0_sclk_out;
      oe_all[PIPB_P22] = 1'b1;
      alt_all[PIPB_P20] = sio0_so;
      oe_all[PIPB_P20] = 1'b1;
    end
    if (uart_on) begin
      // Swap moves transmit from P20 to P21
      if (st_reg.swap) begin
        alt_all[PIPB_P21] = uart0_txd;
        oe_all[PIPB_P21] = 1'b1;
      end else begin
        alt_all[PIPB_P20] = uart0_txd;
        oe_all[PIPB_P20] = 1'b1;
      end
    end
  end

  // Bus answer, global registers, peripheral input copies
  always_comb begin
    st_next = st_reg;
    st_next.ack = req & !st_reg.ack;
    if (req && !st_reg.ack) begin
      // Read data sampled in the read cycle
      st_next.dat = 32'h0000_0000;
      if (port_sel < 4'(PIPB_NPORT)) begin
        st_next.dat[7:0] = port_rd[port_sel];
      end else if (port_sel == PIPB_GLOBAL_PORT) begin
        case (reg_idx)
          PIPB_G_ROUTE: st_next.dat[2:0] = st_reg.route;
          PIPB_G_SWAP: st_next.dat[0] = st_reg.swap;
          default: ;
        endcase
      end
    end
    if (wr_now && port_sel == PIPB_GLOBAL_PORT) begin
      case (reg_idx)
        PIPB_G_ROUTE: st_next.route = wb_dat_i[2:0];
        PIPB_G_SWAP: st_next.swap = wb_dat_i[0];
        default: ;
      endcase
    end
    // Unrouted peripheral inputs idle high
    st_next.scl = s0[0] ? 1'b1 : pin_in[PIPB_P24];
    st_next.sda = s0[0] ? 1'b1 : pin_in[PIPB_P23];
    if (s0 == PIPB_S0_SIO_HI) begin
      st_next.si = pin_in[PIPB_P24];
      st_next.sclk = pin_in[PIPB_P25];
    end else if (sio_lo) begin
      st_next.si = pin_in[PIPB_P21];
      st_next.sclk = pin_in[PIPB_P22];
    end else begin
      st_next.si = 1'b1;
      st_next.sclk = 1'b1;
    end
    if (uart_on) begin
      st_next.rxd = st_reg.swap ? pin_in[PIPB_P20] : pin_in[PIPB_P21];
    end else begin
      st_next.rxd = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.dat;
  assign uart0_rxd = st_reg.rxd;
  assign sio0_si = st_reg.si;
  assign sio0_sclk_in = st_reg.sclk;
  assign twi_scl_in = st_reg.scl;
  assign twi_sda_in = st_reg.sda;

  // One port block per documented port
  for (genvar g = 0; g < PIPB_NPORT; g++) begin : g_port
    assign port_wr[g] = wr_now && port_sel == 4'(g);
    pipb_port #(
      .W(PIPB_W[g]),
      .FC_MASK(PIPB_FC_MASK[g]),
      .OC_MASK(PIPB_OC_MASK[g]),
      .PU_MASK(PIPB_PU_MASK[g])
    ) u_port (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .wr_en(port_wr[g]),
      .reg_idx(reg_idx),
      .wr_data(wb_dat_i[7:0]),
      .rd_data(port_rd[g]),
      .pin_in(pin_in[PIPB_BASE[g] +: PIPB_W[g]]),
      .alt_out(alt_all[PIPB_BASE[g] +: PIPB_W[g]]),
      .alt_oe(oe_all[PIPB_BASE[g] +: PIPB_W[g]]),
      .pin_out(pin_out[PIPB_BASE[g] +: PIPB_W[g]]),
      .pin_oe_n(pin_oe_n[PIPB_BASE[g] +: PIPB_W[g]]),
      .pin_pu(pin_pullup[PIPB_BASE[g] +: PIPB_W[g]])
    );
  end

  ack_single_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    req && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  pin_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    req && !wb_ack_o && !wb_we_i && port_sel == 4'h0
    && reg_idx == PIPB_R_PIN
    |=> wb_dat_o == {28'h0000000, $past(pin_in[3:0])})
    else $error("pin read does not show sampled level");
  twi_route_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !s0[0] |=> twi_scl_in == $past(pin_in[PIPB_P24]))
    else $error("two-wire clock not routed");
  uart_swap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    uart_on && st_reg.swap |=> uart0_rxd == $past(pin_in[PIPB_P20]))
    else $error("swapped receive pin wrong");
  tx_pin_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    uart_on && !st_reg.swap && !sio_lo |-> oe_all[PIPB_P20]
    && !oe_all[PIPB_P21] && alt_all[PIPB_P20] == uart0_txd)
    else $error("transmit not on P20");
  alt_block_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    alt_oe_i[PIPB_BASE[3]] == 1'b0 |=> pin_oe_n[PIPB_BASE[3]]
    || $past(g_port[3].u_port.st_reg.fc[0]) == 1'b0)
    else $error("alternate drove without consent");
  pullup_pp_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 (pin_pullup[PIPB_P25:PIPB_P20]
    & $past(g_port[2].u_port.st_reg.cr[5:0]
    & ~g_port[2].u_port.st_reg.oc[5:0])) == 6'h00)
    else $error("pull-up on push-pull output");
endmodule

// file: pipb_pins.sv
module pipb_pins import pipb_pkg::*; (
  input wire logic sys_clk,
  input wire logic [PIPB_NPIN-1:0] pin_out,
  input wire logic [PIPB_NPIN-1:0] pin_oe_n,
  input wire logic [PIPB_NPIN-1:0] pin_pullup,
  input wire logic [PIPB_NPIN-1:0] ext_en,
  input wire logic [PIPB_NPIN-1:0] ext_val,
  output logic [PIPB_NPIN-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PIPB_NPIN-1:0] last_reg = '0; // Known start, never unknown
  // Pad level: device drive, outside drive, pull-up, else a drifting level
  always_comb begin
    for (int i = 0; i < PIPB_NPIN; i++) begin
      if (!pin_oe_n[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = ~last_reg[i];
    end
  end
  // Floating pads flip each cycle so no stale level is read
  always_ff @(posedge sys_clk) begin
    last_reg <= pin_in;
  end
endmodule

// file: pipb_bank_tb.sv
module pipb_bank_tb import pipb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0;
  logic resetn = 0;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [8:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] dat = '0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic ack;
  logic [45:0] pin_in, pin_out, oe_n, pu;
  logic [45:0] aout = '0;
  logic [45:0] aoe = '0;
  logic [45:0] xen = '0;
  logic [45:0] xval = '0;
  logic utx = 0;
  logic so = 0;
  logic urx, si;
  logic scl_lo = 0;
  logic sck = 0;
  logic scl_in, sda_in, sck_in;
  int error_cnt = 0;
  int total_checks = 0;

  pipb_bank u_pipb_bank (.sys_clk(sys_clk), .resetn(resetn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n),
    .pin_pullup(pu), .alt_out_i(aout), .alt_oe_i(aoe),
    .uart0_txd(utx), .sio0_sclk_out(sck), .sio0_so(so),
    .twi_scl_low(scl_lo), .twi_sda_low(1'b0), .uart0_rxd(urx),
    .sio0_si(si), .sio0_sclk_in(sck_in), .twi_scl_in(scl_in),
    .twi_sda_in(sda_in));
  pipb_pins u_pipb_pins (.sys_clk(sys_clk), .pin_out(pin_out),
    .pin_oe_n(oe_n), .pin_pullup(pu), .ext_en(xen), .ext_val(xval),
    .pin_in(pin_in));

  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [8:0] ra(input int p, input logic [2:0] r);
    return {4'(p), r, 2'b00};
  endfunction

  // One classic cycle, held until ack is sampled high
  task automatic xfer(input logic [8:0] a, input logic w,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    check("wb_ack", 1, ack);
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input string nm, input logic [8:0] a,
                    input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    check(nm, {24'h0, e}, q);
  endtask

  // Let two edges land, then look
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("oe_n reset", {46{1'b1}}, oe_n);
    check("pullup reset", 0, pu);
    // Start-up: unused direction bits set to one
    wr(ra(1, PIPB_R_DIR), 8'h0C);
    wr(ra(2, PIPB_R_DIR), 8'hF0);
    wr(ra(4, PIPB_R_DIR), 8'hFF);
    wr(ra(6, PIPB_R_DIR), 8'h1C);
    wr(ra(8, PIPB_R_DIR), 8'hC0);
    rd("dir p8", ra(6, PIPB_R_DIR), 8'h1C);
    // Control sets per port; port 0 low pins stay oscillator
    for (int p = 0; p < 9; p++) begin
      wr(ra(p, PIPB_R_ALT), 8'hFF);
      wr(ra(p, PIPB_R_DRV), 8'hFF);
      wr(ra(p, PIPB_R_PU), 8'hFF);
      rd("alt", ra(p, PIPB_R_ALT), PIPB_FC_MASK[p]);
      rd("drv", ra(p, PIPB_R_DRV), PIPB_OC_MASK[p]);
      rd("pu", ra(p, PIPB_R_PU), PIPB_PU_MASK[p]);
      wr(ra(p, PIPB_R_ALT), 8'h00);
      wr(ra(p, PIPB_R_DRV), 8'h00);
      wr(ra(p, PIPB_R_PU), 8'h00);
    end
    rd("unmapped", 9'h140, 8'h00);
    rd("hole", ra(3, 3'h6), 8'h00);
    xen[3:0] <= 4'hF;
    xval[3:0] <= 4'h9;
    rd("p0 pins", ra(0, PIPB_R_PIN), 8'h09);
    $display("test map done");
    // Latched output on P4, one cycle after the write
    wr(ra(3, PIPB_R_DATA), 8'hA5);
    wr(ra(3, PIPB_R_DIR), 8'hFF);
    #1;
    check("oe_n early", 8'hFF, oe_n[19:12]);
    settle();
    check("p4 out", 8'hA5, pin_out[19:12]);
    check("p4 oe_n", 8'h00, oe_n[19:12]);
    // Plain output on P5 shows one cycle after the write
    wr(ra(4, PIPB_R_DATA), 8'h15);
    @(posedge sys_clk);
    #1;
    check("p5 out", 5'h15, pin_out[24:20]);
    check("p5 oe_n", 5'h00, oe_n[24:20]);
    // Mixed directions, live input reads
    wr(ra(3, PIPB_R_DIR), 8'h0F);
    xen[19:16] <= 4'hF;
    xval[19:16] <= 4'hA;
    rd("p4 pins", ra(3, PIPB_R_PIN), 8'hA5);
    xval[19:16] <= 4'h3;
    rd("p4 live", ra(3, PIPB_R_PIN), 8'h35);
    $display("test io done");
    // Open drain and pull-up on PB
    wr(ra(8, PIPB_R_DATA), 8'h2A);
    wr(ra(8, PIPB_R_DIR), 8'h3F);
    wr(ra(8, PIPB_R_DRV), 8'h3F);
    wr(ra(8, PIPB_R_PU), 8'h3F);
    settle();
    check("od out", 0, pin_out[45:40]);
    check("od oe_n", 6'h2A, oe_n[45:40]);
    check("od pu", 6'h3F, pu[45:40]);
    rd("od pins", ra(8, PIPB_R_PIN), 8'h2A);
    wr(ra(8, PIPB_R_DRV), 8'h00);
    settle();
    check("pp out", 6'h2A, pin_out[45:40]);
    check("pp pu", 0, pu[45:40]);
    wr(ra(8, PIPB_R_DIR), 8'h00);
    settle();
    check("in pu", 6'h3F, pu[45:40]);
    $display("test drive done");
    // Alternate output on P7
    wr(ra(5, PIPB_R_DIR), 8'hFF);
    aout[32:25] <= 8'h3C;
    aoe[32:25] <= 8'hF0;
    wr(ra(5, PIPB_R_ALT), 8'hFF);
    settle();
    check("alt out", 8'h3C, pin_out[32:25]);
    check("alt oe_n", 8'h0F, oe_n[32:25]);
    wr(ra(5, PIPB_R_ALT), 8'h00);
    settle();
    check("plain out", 8'h00, pin_out[32:25]);
    check("plain oe_n", 8'h00, oe_n[32:25]);
    $display("test alt done");
    // Port 2 routing: two-wire, UART, swapped UART, serial 01 and 10
    wr(ra(2, PIPB_R_DIR), 8'h18);
    scl_lo <= 1'b1;
    xen[9] <= 1'b1;
    xval[9] <= 1'b1;
    wr(ra(2, PIPB_R_ALT), 8'h18);
    settle();
    check("twi oe_n", 2'b01, {oe_n[10], oe_n[9]});
    check("twi out", 0, pin_out[10]);
    check("twi in", 2'b01, {scl_in, sda_in});
    wr(ra(2, PIPB_R_DIR), 8'h01);
    scl_lo <= 1'b0;
    wr(ra(2, PIPB_R_ALT), 8'h01);
    utx <= 1'b1;
    xen[7] <= 1'b1;
    xval[7] <= 1'b0;
    settle();
    check("tx p20", 1, pin_out[6]);
    check("rx p21", 0, urx);
    wr({PIPB_GLOBAL_PORT, PIPB_G_SWAP, 2'b00}, 8'h01);
    wr(ra(2, PIPB_R_DIR), 8'h02);
    wr(ra(2, PIPB_R_ALT), 8'h02);
    xen[7] <= 1'b0;
    xen[6] <= 1'b1;
    xval[6] <= 1'b0;
    settle();
    check("tx p21", 1, pin_out[7]);
    check("rx p20", 0, urx);
    wr({PIPB_GLOBAL_PORT, PIPB_G_ROUTE, 2'b00}, {6'h0, PIPB_S0_SIO_HI});
    wr(ra(2, PIPB_R_DIR), 8'h28);
    so <= 1'b1;
    sck <= 1'b1;
    wr(ra(2, PIPB_R_ALT), 8'h28);
    xen[10] <= 1'b1;
    xval[10] <= 1'b0;
    settle();
    check("so p23", 1, pin_out[9]);
    check("sclk p25", 1, pin_out[11]);
    check("si p24", 0, si);
    check("sclk in", 1, sck_in);
    check("twi idle", 2'b11, {scl_in, sda_in});
    wr({PIPB_GLOBAL_PORT, PIPB_G_ROUTE, 2'b00}, {6'h0, PIPB_S0_SIO_LO});
    wr(ra(2, PIPB_R_DIR), 8'h05);
    sck <= 1'b0;
    xen[7] <= 1'b1;
    xval[7] <= 1'b1;
    wr(ra(2, PIPB_R_ALT), 8'h05);
    settle();
    check("so p20", 1, pin_out[6]);
    check("sclk p22", 0, pin_out[8]);
    check("sclk oe_n", 0, oe_n[8]);
    check("sclk in lo", 0, sck_in);
    check("si p21", 1, si);
    check("rx idle", 1, urx);
    $display("test route done");
    close_out();
  end
endmodule
